/* ahbi_pkg.sv */
// Constants and types shared by the asynchronous host bus interface
`default_nettype none
package ahbi_pkg;
    // Host pin widths and core-side interrupt source width
    localparam int ADDR_W = 7;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int IRQ_W = 16;
    // Locally decoded halfword registers, byte offsets on the host address bus
    localparam logic [7:0] OFS_RX_FRAME_PTR = 8'hF0;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'hF2;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'hF4;
    // Field positions and reset values
    localparam int ENDIAN_BIT = 11;
    localparam logic [15:0] RX_FRAME_PTR_RST = 16'h0000;
    localparam logic [15:0] IRQ_ENABLE_RST = 16'h0000;
    // Lane masks, bit n set means byte lane n takes part
    localparam logic [3:0] MASK_NONE = 4'h0;
    localparam logic [3:0] MASK_B0 = 4'h1;
    localparam logic [3:0] MASK_B1 = 4'h2;
    localparam logic [3:0] MASK_B2 = 4'h4;
    localparam logic [3:0] MASK_B3 = 4'h8;
    localparam logic [3:0] MASK_LO = 4'h3;
    localparam logic [3:0] MASK_HI = 4'hC;
    localparam logic [3:0] MASK_ALL = 4'hF;
    // Active-low lane select codes, bit order {lane3..lane0}
    localparam logic [3:0] SEL_ALL = 4'h0;
    localparam logic [3:0] SEL_LO = 4'hC;
    localparam logic [3:0] SEL_HI = 4'h3;
    localparam logic [3:0] SEL_B0 = 4'hE;
    localparam logic [3:0] SEL_B1 = 4'hD;
    localparam logic [3:0] SEL_B2 = 4'hB;
    localparam logic [3:0] SEL_B3 = 4'h7;

    typedef enum logic [1:0] {
        AHBI_BUS8 = 2'h0,
        AHBI_BUS16 = 2'h1,
        AHBI_BUS32 = 2'h2
    } ahbi_width_t;

    typedef enum logic [2:0] {
        AHBI_IDLE = 3'h1,
        AHBI_ACCESS = 3'h2,
        AHBI_HOLD = 3'h4
    } ahbi_state_t;

    // One captured host access as presented to the core
    typedef struct packed {
        logic wr;
        logic local_hit;
        logic [6:0] addr;
        logic [3:0] mask;
        logic [31:0] wdata;
    } ahbi_acc_t;
endpackage
`default_nettype wire

/* ahbi_host_port.sv */
// Device-side asynchronous host bus interface with lane steering and endian swap
`default_nettype none
module ahbi_host_port (
    // Clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // Host bus pins
    input wire logic [ahbi_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_addr_qualifier_n,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    input wire logic [ahbi_pkg::LANES-1:0] i_lane_select_n,
    input wire logic [ahbi_pkg::DATA_W-1:0] i_data,
    output logic [ahbi_pkg::DATA_W-1:0] o_data,
    output logic o_data_oe,
    output logic o_wait_ready,
    output logic o_target_select_n,
    output logic o_irq_out_n,
    // Straps, caught once after reset
    input wire logic i_endian_strap,
    input wire logic i_bus_width_strap,
    input wire logic i_bus32_fitted,
    // Core side
    output ahbi_pkg::ahbi_acc_t o_core_cmd,
    output logic o_core_req,
    input wire logic i_core_ack,
    input wire logic [ahbi_pkg::DATA_W-1:0] i_core_rdata,
    input wire logic [ahbi_pkg::IRQ_W-1:0] i_irq_src
);
    // Decode active-low lane selects into a lane mask; zero means refused
    function automatic logic [3:0] lane_mask(input logic [3:0] sel_n,
                                             input ahbi_pkg::ahbi_width_t w);
        logic [3:0] m;
        m = ahbi_pkg::MASK_NONE;
        case (w)
            ahbi_pkg::AHBI_BUS8:
                // Lane 1 is the inverse of lane 0, so lane 0 acts as A0
                m = sel_n[0] ? ahbi_pkg::MASK_B1 : ahbi_pkg::MASK_B0;
            ahbi_pkg::AHBI_BUS16:
                if (sel_n[1:0] == ahbi_pkg::SEL_LO[1:0])
                    m = ahbi_pkg::MASK_LO;
                else if (sel_n[1:0] == ahbi_pkg::SEL_B0[1:0])
                    m = ahbi_pkg::MASK_B0;
                else if (sel_n[1:0] == ahbi_pkg::SEL_B1[1:0])
                    m = ahbi_pkg::MASK_B1;
            default:
                if (sel_n == ahbi_pkg::SEL_ALL)
                    m = ahbi_pkg::MASK_ALL;
                else if (sel_n == ahbi_pkg::SEL_LO)
                    m = ahbi_pkg::MASK_LO;
                else if (sel_n == ahbi_pkg::SEL_HI)
                    m = ahbi_pkg::MASK_HI;
                else if (sel_n == ahbi_pkg::SEL_B0)
                    m = ahbi_pkg::MASK_B0;
                else if (sel_n == ahbi_pkg::SEL_B1)
                    m = ahbi_pkg::MASK_B1;
                else if (sel_n == ahbi_pkg::SEL_B2)
                    m = ahbi_pkg::MASK_B2;
                else if (sel_n == ahbi_pkg::SEL_B3)
                    m = ahbi_pkg::MASK_B3;
        endcase
        return m;
    endfunction

    // Byte reversal within the selected span; single bytes pass untouched
    function automatic logic [31:0] order_swap(input logic [31:0] d, input logic [3:0] m,
                                               input logic big);
        logic [31:0] r;
        r = d;
        if (big)
        begin
            if (m == ahbi_pkg::MASK_ALL)
                r = {d[7:0], d[15:8], d[23:16], d[31:24]};
            else if (m == ahbi_pkg::MASK_LO || m == ahbi_pkg::MASK_HI)
                r = {d[23:16], d[31:24], d[7:0], d[15:8]};
        end
        return r;
    endfunction

    ahbi_pkg::ahbi_state_t state, next_state;
    ahbi_pkg::ahbi_acc_t acc, next_acc;
    logic [31:0] next_data;
    logic next_data_oe, next_wait_ready, next_core_req;
    logic [15:0] rx_frame_ptr, next_rx_frame_ptr;
    logic [15:0] irq_en, next_irq_en;
    logic rd_meta, rd_sync, rd_prev, wr_meta, wr_sync, wr_prev;
    logic endian_q, width_q, bus32_q, straps_taken;
    logic rd_fall, wr_fall, rd_rise, wr_rise, start, local_done;
    logic big_endian;
    ahbi_pkg::ahbi_width_t width;
    logic [3:0] cur_mask;
    logic [31:0] host_word;
    logic [15:0] local_rd, wr_half;

    // Strobes enter through two flops; edges are seen only past the second
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rd_meta <= 1'b1;
            rd_sync <= 1'b1;
            rd_prev <= 1'b1;
            wr_meta <= 1'b1;
            wr_sync <= 1'b1;
            wr_prev <= 1'b1;
        end
        else if (i_clk_en)
        begin
            rd_meta <= i_read_strobe_n;
            rd_sync <= rd_meta;
            rd_prev <= rd_sync;
            wr_meta <= i_write_strobe_n;
            wr_sync <= wr_meta;
            wr_prev <= wr_sync;
        end
    end

    // Straps are caught at the first enabled edge after reset release
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            endian_q <= 1'b0;
            width_q <= 1'b0;
            bus32_q <= 1'b0;
            straps_taken <= 1'b0;
        end
        else if (i_clk_en && !straps_taken)
        begin
            endian_q <= i_endian_strap;
            width_q <= i_bus_width_strap;
            bus32_q <= i_bus32_fitted;
            straps_taken <= 1'b1;
        end
    end

    always_comb
    begin
        rd_fall = rd_prev && !rd_sync;
        wr_fall = wr_prev && !wr_sync;
        rd_rise = !rd_prev && rd_sync;
        wr_rise = !wr_prev && wr_sync;
        // Strap high forces big; otherwise the config bit decides
        big_endian = endian_q || rx_frame_ptr[ahbi_pkg::ENDIAN_BIT];
        if (bus32_q)
            width = ahbi_pkg::AHBI_BUS32;
        else if (width_q)
            width = ahbi_pkg::AHBI_BUS16;
        else
            width = ahbi_pkg::AHBI_BUS8;
        cur_mask = lane_mask(i_lane_select_n, width);
        // Narrow hosts are replicated onto every lane; the mask picks the lane
        if (width == ahbi_pkg::AHBI_BUS8)
            host_word = {4{i_data[7:0]}};
        else if (width == ahbi_pkg::AHBI_BUS16)
            host_word = {2{i_data[15:0]}};
        else
            host_word = i_data;
        // Address taken straight off the pins while qualifier is low
        start = (rd_fall || wr_fall) && !i_addr_qualifier_n
                && cur_mask != ahbi_pkg::MASK_NONE;
        local_done = acc.local_hit;
        if ({acc.addr, 1'b0} == ahbi_pkg::OFS_RX_FRAME_PTR)
            local_rd = rx_frame_ptr;
        else if ({acc.addr, 1'b0} == ahbi_pkg::OFS_IRQ_ENABLE)
            local_rd = irq_en;
        else
            local_rd = i_irq_src;
        wr_half = (acc.mask[2] || acc.mask[3]) ? acc.wdata[31:16] : acc.wdata[15:0];
    end

    always_comb
    begin
        next_state = state;
        next_acc = acc;
        next_data = o_data;
        next_data_oe = o_data_oe;
        next_wait_ready = o_wait_ready;
        next_core_req = 1'b0;
        next_rx_frame_ptr = rx_frame_ptr;
        next_irq_en = irq_en;
        case (state)
            ahbi_pkg::AHBI_IDLE:
                if (start)
                begin
                    next_acc.wr = wr_fall;
                    next_acc.addr = i_addr;
                    next_acc.mask = cur_mask;
                    // Write data is taken at the strobe fall, order-swapped
                    next_acc.wdata = order_swap(host_word, cur_mask, big_endian);
                    next_acc.local_hit = ({i_addr, 1'b0} == ahbi_pkg::OFS_RX_FRAME_PTR)
                                      || ({i_addr, 1'b0} == ahbi_pkg::OFS_IRQ_ENABLE)
                                      || ({i_addr, 1'b0} == ahbi_pkg::OFS_IRQ_STATUS);
                    next_core_req = !next_acc.local_hit;
                    next_wait_ready = 1'b0;
                    next_state = ahbi_pkg::AHBI_ACCESS;
                end
            ahbi_pkg::AHBI_ACCESS:
                if (local_done || i_core_ack)
                begin
                    if (local_done && acc.wr)
                    begin
                        if ({acc.addr, 1'b0} == ahbi_pkg::OFS_RX_FRAME_PTR)
                        begin
                            if (acc.mask[0] || acc.mask[2])
                                next_rx_frame_ptr[7:0] = wr_half[7:0];
                            if (acc.mask[1] || acc.mask[3])
                                next_rx_frame_ptr[15:8] = wr_half[15:8];
                        end
                        else if ({acc.addr, 1'b0} == ahbi_pkg::OFS_IRQ_ENABLE)
                        begin
                            if (acc.mask[0] || acc.mask[2])
                                next_irq_en[7:0] = wr_half[7:0];
                            if (acc.mask[1] || acc.mask[3])
                                next_irq_en[15:8] = wr_half[15:8];
                        end
                    end
                    next_data = order_swap(local_done ? {2{local_rd}} : i_core_rdata,
                                           acc.mask, big_endian);
                    if (width == ahbi_pkg::AHBI_BUS8)
                        next_data = {24'h000000, acc.mask[1] ? next_data[15:8]
                                    : next_data[7:0]};
                    else if (width == ahbi_pkg::AHBI_BUS16)
                        next_data = {16'h0000, next_data[15:0]};
                    next_data_oe = !acc.wr;
                    next_wait_ready = 1'b1;
                    next_state = ahbi_pkg::AHBI_HOLD;
                end
            ahbi_pkg::AHBI_HOLD:
                // Read data stays driven until the host's latching edge
                if (rd_rise || wr_rise)
                begin
                    next_data_oe = 1'b0;
                    next_state = ahbi_pkg::AHBI_IDLE;
                end
            default:
                next_state = ahbi_pkg::AHBI_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= ahbi_pkg::AHBI_IDLE;
            acc <= '0;
            o_data <= 32'h00000000;
            o_data_oe <= 1'b0;
            o_wait_ready <= 1'b1;
            o_core_req <= 1'b0;
            rx_frame_ptr <= ahbi_pkg::RX_FRAME_PTR_RST;
            irq_en <= ahbi_pkg::IRQ_ENABLE_RST;
            o_target_select_n <= 1'b1;
            o_irq_out_n <= 1'b1;
        end
        else if (i_clk_en)
        begin
            state <= next_state;
            acc <= next_acc;
            o_data <= next_data;
            o_data_oe <= next_data_oe;
            o_wait_ready <= next_wait_ready;
            o_core_req <= next_core_req;
            rx_frame_ptr <= next_rx_frame_ptr;
            irq_en <= next_irq_en;
            // Registered, so it trails the pins by one clock
            o_target_select_n <= i_addr_qualifier_n;
            o_irq_out_n <= !(|(i_irq_src & irq_en));
        end
    end

    assign o_core_cmd = acc;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_ready_drop_start: assert property (i_clk_en && state == ahbi_pkg::AHBI_IDLE && start
        |=> !o_wait_ready) else $error("ready not lowered at strobe fall");
    a_ready_low_pending: assert property (state == ahbi_pkg::AHBI_ACCESS && !local_done
        && !i_core_ack |=> !o_wait_ready) else $error("ready high before completion");
    a_ready_after_ack: assert property (i_clk_en && state == ahbi_pkg::AHBI_ACCESS
        && i_core_ack |=> o_wait_ready && state == ahbi_pkg::AHBI_HOLD)
        else $error("ready not raised on completion");
    a_target_follows_qual: assert property (i_clk_en |=>
        o_target_select_n == $past(i_addr_qualifier_n)) else $error("target select wrong");
    a_irq_level_pending: assert property (i_clk_en |=>
        o_irq_out_n == !(|($past(i_irq_src) & $past(irq_en)))) else $error("irq level wrong");
    a_read_held_hold: assert property (state == ahbi_pkg::AHBI_HOLD && !acc.wr
        && !rd_rise |=> o_data_oe) else $error("read data released early");
    a_oe_off_rise: assert property (i_clk_en && state == ahbi_pkg::AHBI_HOLD
        && (rd_rise || wr_rise) |=> !o_data_oe && state == ahbi_pkg::AHBI_IDLE)
        else $error("data not released at strobe rise");
    a_byte_only_eight: assert property (i_clk_en && start && width == ahbi_pkg::AHBI_BUS8
        |=> $onehot(acc.mask) && acc.mask[3:2] == 2'h0) else $error("wide access in 8-bit");
    a_low_lanes_sixteen: assert property (i_clk_en && start
        && width == ahbi_pkg::AHBI_BUS16 |=> acc.mask[3:2] == 2'h0) else $error("upper lane");
    a_no_start_qual: assert property (i_addr_qualifier_n |-> !start)
        else $error("decode without qualifier");
    a_req_one_pulse: assert property (o_core_req |=> !o_core_req)
        else $error("core request longer than one cycle");

    c_read_done: cover property (state == ahbi_pkg::AHBI_HOLD && !acc.wr && rd_rise);
    c_write_done: cover property (state == ahbi_pkg::AHBI_HOLD && acc.wr && wr_rise);
    c_word_access: cover property (start && cur_mask == ahbi_pkg::MASK_ALL);
    c_big_halfword: cover property (start && big_endian && cur_mask == ahbi_pkg::MASK_LO);
endmodule
`default_nettype wire

/* ahbi_host_port_unused_note_placeholder.sv */
// Empty compilation unit kept for tool flows that expect a second source file
`default_nettype none
`default_nettype wire

/* ahbi_host_model.sv */
// Host processor model driving the asynchronous strobe bus
`default_nettype none
module ahbi_host_model (
    // Clock
    input wire logic i_core_clk,
    // From device
    input wire logic [31:0] i_rdata,
    input wire logic i_wait_ready,
    input wire logic i_target_select_n,
    // To device
    output logic [6:0] o_addr,
    output logic o_addr_qualifier_n,
    output logic o_read_strobe_n,
    output logic o_write_strobe_n,
    output logic [3:0] o_lane_select_n,
    output logic [31:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        o_addr = 7'h00;
        o_addr_qualifier_n = 1'b1;
        o_read_strobe_n = 1'b1;
        o_write_strobe_n = 1'b1;
        o_lane_select_n = 4'hF;
        o_data = 32'h0000_0000;
    end

    // One single transfer; a burst is just back-to-back calls
    task automatic access(input logic wr, input logic [6:0] a, input logic [3:0] sel,
        input logic [31:0] wd, input logic qn, output logic [31:0] rd, output logic busy,
        output logic tsel);
        int n;
        begin
            busy = 1'b0;
            @(posedge i_core_clk);
            o_addr <= a;
            o_addr_qualifier_n <= qn;
            o_lane_select_n <= sel;
            if (wr)
                o_data <= wd;
            @(posedge i_core_clk);
            if (wr)
                o_write_strobe_n <= 1'b0;
            else
                o_read_strobe_n <= 1'b0;
            @(negedge i_core_clk);
            tsel = i_target_select_n;
            for (n = 0; n < 12 && !busy; n++)
            begin
                @(negedge i_core_clk);
                busy = (i_wait_ready === 1'b0);
            end
            // Strobe held while ready is low, data taken before the rise
            for (n = 0; n < 80 && busy && i_wait_ready !== 1'b1; n++)
                @(negedge i_core_clk);
            rd = i_rdata;
            @(posedge i_core_clk);
            o_read_strobe_n <= 1'b1;
            o_write_strobe_n <= 1'b1;
            o_addr_qualifier_n <= 1'b1;
            // Released data lines show the inverse so stale values cannot match
            o_data <= ~o_data;
            repeat (5) @(posedge i_core_clk);
        end
    endtask
endmodule
`default_nettype wire

/* ahbi_host_port_bench.sv */
// Self-checking bench for the host port with a behavioural core responder
`default_nettype none
module ahbi_host_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] SELS [7] = '{4'h0, 4'hC, 4'h3, 4'hE, 4'hD, 4'hB, 4'h7};
    localparam logic [3:0] MASKS [7] = '{4'hF, 4'h3, 4'hC, 4'h1, 4'h2, 4'h4, 4'h8};
    logic clk = 1'b0;
    logic rst_n, e_strap, w_strap, bus32, core_ack, core_req;
    logic qual_n, rd_n, wr_n, oe, ready, tsel_n, irq_n, busy, tsel;
    logic [6:0] addr;
    logic [3:0] sel_n;
    logic [15:0] irq_src;
    logic [31:0] core_rdata, rd, din, dout;
    ahbi_pkg::ahbi_acc_t cmd, cmd_q;
    int err_total = 0;
    int cmp_count = 0;
    int req_count = 0;
    int ack_cnt = 0;
    int core_lat = 1;
    int n;
    int oe_hits = 0;
    logic clk_en = 1'b1;

    always #5 clk = ~clk;

    // Counts cycles in which read data is driven while the read strobe is low
    always @(negedge clk)
    begin
        if (rd_n === 1'b0 && oe === 1'b1)
            oe_hits++;
    end

    ahbi_host_port ahbi_host_port_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
        .i_addr(addr), .i_addr_qualifier_n(qual_n), .i_read_strobe_n(rd_n),
        .i_write_strobe_n(wr_n), .i_lane_select_n(sel_n), .i_data(din), .o_data(dout),
        .o_data_oe(oe), .o_wait_ready(ready), .o_target_select_n(tsel_n), .o_irq_out_n(irq_n),
        .i_endian_strap(e_strap), .i_bus_width_strap(w_strap), .i_bus32_fitted(bus32),
        .o_core_cmd(cmd), .o_core_req(core_req), .i_core_ack(core_ack),
        .i_core_rdata(core_rdata), .i_irq_src(irq_src));

    ahbi_host_model ahbi_host_model_inst (.i_core_clk(clk), .i_rdata(dout),
        .i_wait_ready(ready), .i_target_select_n(tsel_n), .o_addr(addr),
        .o_addr_qualifier_n(qual_n), .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n),
        .o_lane_select_n(sel_n), .o_data(din));

    // Core responder, latency set per scenario to exercise long waits
    always @(posedge clk)
    begin
        core_ack <= 1'b0;
        if (core_req === 1'b1)
        begin
            cmd_q <= cmd;
            req_count <= req_count + 1;
            ack_cnt <= core_lat;
        end
        else if (ack_cnt > 0)
        begin
            ack_cnt <= ack_cnt - 1;
            if (ack_cnt == 1)
                core_ack <= 1'b1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic xfer(input logic wr, input logic [6:0] a, input logic [3:0] sel,
        input logic [31:0] wd, input logic qn, input logic exp_busy);
        int h;
        h = oe_hits;
        ahbi_host_model_inst.access(wr, a, sel, wd, qn, rd, busy, tsel);
        check({31'h0, busy}, {31'h0, exp_busy});
        check({31'h0, tsel}, {31'h0, qn});
        check({31'h0, oe_hits != h}, {31'h0, !wr && exp_busy});
        check({31'h0, oe}, 32'h0);
    endtask

    task automatic do_reset(input logic e, input logic w, input logic b);
        rst_n <= 1'b0;
        e_strap <= e;
        w_strap <= w;
        bus32 <= b;
        repeat (8) @(posedge clk);
        check({28'h0, ready, tsel_n, irq_n, oe}, 32'hE);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    initial
    begin
        rst_n = 1'b0;
        e_strap = 1'b0;
        w_strap = 1'b0;
        bus32 = 1'b1;
        irq_src = 16'h0000;
        core_rdata = 32'h0000_0000;
        do_reset(1'b0, 1'b0, 1'b1);
        n = req_count;
        xfer(1'b1, 7'h78, 4'hC, 32'h0000_1234, 1'b0, 1'b1);
        xfer(1'b0, 7'h78, 4'hC, 32'h0, 1'b0, 1'b1);
        check(rd, 32'h1234_1234);
        xfer(1'b1, 7'h79, 4'hC, 32'h0000_0001, 1'b0, 1'b1);
        irq_src <= 16'h0002;
        repeat (3) @(posedge clk);
        check({31'h0, irq_n}, 32'h1);
        irq_src <= 16'h0001;
        repeat (3) @(posedge clk);
        check({31'h0, irq_n}, 32'h0);
        // Enable low must freeze the interrupt output although the source clears
        clk_en <= 1'b0;
        irq_src <= 16'h0000;
        repeat (3) @(posedge clk);
        check({31'h0, irq_n}, 32'h0);
        clk_en <= 1'b1;
        irq_src <= 16'h0001;
        xfer(1'b0, 7'h7A, 4'hC, 32'h0, 1'b0, 1'b1);
        check(rd, 32'h0001_0001);
        check(req_count, n);
        irq_src <= 16'h0000;
        for (int i = 0; i < 7; i++)
        begin
            xfer(1'b1, 7'h10, SELS[i], 32'hA1B2_C3D4, 1'b0, 1'b1);
            check({28'h0, cmd_q.mask}, {28'h0, MASKS[i]});
        end
        check({24'h0, cmd_q.wr, cmd_q.addr}, {24'h0, 1'b1, 7'h10});
        xfer(1'b1, 7'h10, 4'h0, 32'hA1B2_C3D4, 1'b0, 1'b1);
        check(cmd_q.wdata, 32'hA1B2_C3D4);
        // Slow core keeps the host waiting well past the synchroniser delay
        core_lat = 6;
        core_rdata <= 32'h1122_3344;
        xfer(1'b0, 7'h11, 4'h0, 32'h0, 1'b0, 1'b1);
        check(rd, 32'h1122_3344);
        check({31'h0, cmd_q.wr}, 32'h0);
        xfer(1'b1, 7'h78, 4'hC, 32'h0000_0800, 1'b0, 1'b1);
        xfer(1'b1, 7'h10, 4'h0, 32'hA1B2_C3D4, 1'b0, 1'b1);
        check(cmd_q.wdata, 32'hD4C3_B2A1);
        xfer(1'b0, 7'h10, 4'h0, 32'h0, 1'b0, 1'b1);
        check(rd, 32'h4433_2211);
        n = req_count;
        xfer(1'b0, 7'h10, 4'h0, 32'h0, 1'b1, 1'b0);
        xfer(1'b1, 7'h10, 4'h5, 32'h1, 1'b0, 1'b0);
        check(req_count, n);
        // Byte-only host on the narrow bus, then a 16-bit host, both with the endian strap high
        do_reset(1'b1, 1'b0, 1'b0);
        xfer(1'b1, 7'h20, 4'hE, 32'h0000_005A, 1'b0, 1'b1);
        check({28'h0, cmd_q.mask}, 32'h1);
        xfer(1'b1, 7'h21, 4'hF, 32'h0000_005A, 1'b0, 1'b1);
        check({28'h0, cmd_q.mask}, 32'h2);
        do_reset(1'b1, 1'b1, 1'b0);
        xfer(1'b1, 7'h20, 4'hC, 32'h0000_1234, 1'b0, 1'b1);
        check({28'h0, cmd_q.mask}, 32'h3);
        check({16'h0, cmd_q.wdata[15:0]}, 32'h0000_3412);
        xfer(1'b1, 7'h78, 4'hC, 32'h0000_1234, 1'b0, 1'b1);
        xfer(1'b0, 7'h78, 4'hC, 32'h0, 1'b0, 1'b1);
        check(rd, 32'h0000_1234);
        xfer(1'b1, 7'h20, 4'hE, 32'h0000_0012, 1'b0, 1'b1);
        check({28'h0, cmd_q.mask}, 32'h1);
        report_and_stop();
    end

    // Watchdog sized well above the few hundred cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
endmodule
`default_nettype wire
